// ---- src/lpbpwm_consts.svh ----
// Register offsets, reset values, field positions and timing figures of the LED effect block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef LPBPWM_CONSTS_SVH
`define LPBPWM_CONSTS_SVH
`define LPB_ADDR_PULSE_TWO_PERIOD_FIELD 8'h85
`define LPB_ADDR_BREATHE_PERIOD_FIELD 8'h86
`define LPB_ADDR_CFG 8'h88
`define LPB_ADDR_P1_DUTY 8'h90
`define LPB_ADDR_P2_DUTY 8'h91
`define LPB_ADDR_BR_DUTY 8'h92
`define LPB_ADDR_DR_DUTY 8'h93
`define LPB_RST_PULSE_TWO_PERIOD_FIELD 8'h14
`define LPB_RST_BREATHE_PERIOD_FIELD 8'h5d
`define LPB_RST_CFG 8'h04
`define LPB_RST_DUTY 8'hf0
`define LPB_PER_MASK 8'h7f
`define LPB_CFG_MASK 8'h7f
`define LPB_ALERT_BIT 6
`define LPB_P2CNT_HI 5
`define LPB_P2CNT_LO 3
`define LPB_P1CNT_HI 2
`define LPB_P1CNT_LO 0
`define LPB_TICK_MS 32
`define LPB_CLK_KHZ 25000
`define LPB_MIN_PER_STEPS 7'h05
`define LPB_PWM_MAX 7'h64
`endif

// ---- src/lpbpwm_pkg.sv ----
// Types shared by the LED pulse and breathe effect block.
// Assumes the constants header sits beside it on the include path.
package lpbpwm_pkg;
  `include "lpbpwm_consts.svh"
  typedef enum logic [1:0] {
    LPB_BEH_DIRECT = 2'b00,
    LPB_BEH_PULSE1 = 2'b01,
    LPB_BEH_PULSE2 = 2'b10,
    LPB_BEH_BREATHE = 2'b11
  } lpb_beh_t;
  // Gray-coded along idle, rise, fall, settle.
  typedef enum logic [1:0] {
    LPB_ST_IDLE = 2'b00,
    LPB_ST_RISE = 2'b01,
    LPB_ST_FALL = 2'b11,
    LPB_ST_HOLD = 2'b10
  } lpb_state_t;
endpackage

// ---- src/lpbpwm_top.sv ----
// One LED effect engine: period, count and duty registers plus the ramp and PWM output.
// Assumes a synchronous register port in the ref_clk domain and a 25 MHz ref_clk.
`timescale 1ns/1ps
`include "lpbpwm_consts.svh"

// Summary of operation
// - Pulse 2 period in 32 ms steps
// - Breathe period in 32 ms steps
// - Short periods clamp to the reachable minimum
// - Alert on host-started effect completion
// - Touch-started effects raise no alert
// - Pulse 2 breaths are code plus one
// - Pulse 1 breaths are code plus one
// - Separate duty limits per behaviour
// - Maximum duty code decode table
// - Minimum duty code decode table
// - Ramp minimum to maximum then back
// - Direct duty changes apply at once
// - Other behaviours latch settings on actuation
// - Pulse 2 counts breaths after stop
// - Rise and fall each half period
module lpbpwm_top #(
  parameter int TICK_CYCLES = (`LPB_CLK_KHZ * `LPB_TICK_MS)
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire lpbpwm_pkg::lpb_beh_t led_behaviour_select,
  input wire logic led_polarity,
  input wire logic act_level,
  input wire logic act_by_host,
  output logic led_pwm,
  output logic alert_n
);
  import lpbpwm_pkg::*;

  typedef struct packed {
    logic [7:0] pulse_two_period_field;
    logic [7:0] breathe_period_field;
    logic [7:0] cfg;
    logic [7:0] p1_duty;
    logic [7:0] p2_duty;
    logic [7:0] br_duty;
    logic [7:0] dr_duty;
    logic [7:0] rdata;
    logic [22:0] tick_cnt;
    lpb_state_t st;
    lpb_beh_t beh;
    logic [6:0] lo;
    logic [6:0] hi;
    logic [6:0] half;
    logic [6:0] step;
    logic [3:0] left;
    logic host;
    logic stopping;
    logic act_d;
    logic [6:0] duty;
    logic [6:0] pwm_cnt;
    logic pwm;
    logic alert_n;
  } lpb_reg_t;

  lpb_reg_t q_r;
  lpb_reg_t q_nxt;

  // Top duty decode in percent.
  function automatic logic [6:0] top_pct(input logic [3:0] c);
    logic [6:0] p;
    case (c)
      4'h0: p = 7'd7;
      4'h1: p = 7'd9;
      4'h2: p = 7'd11;
      4'h3: p = 7'd14;
      4'h4: p = 7'd17;
      4'h5: p = 7'd20;
      4'h6: p = 7'd23;
      4'h7: p = 7'd26;
      4'h8: p = 7'd30;
      4'h9: p = 7'd35;
      4'ha: p = 7'd40;
      4'hb: p = 7'd46;
      4'hc: p = 7'd53;
      4'hd: p = 7'd63;
      4'he: p = 7'd77;
      default: p = 7'd100;
    endcase
    return p;
  endfunction

  // Floor duty decode is the top table shifted down one code.
  function automatic logic [6:0] floor_pct(input logic [3:0] c);
    logic [6:0] p;
    p = (c == 4'h0) ? 7'd0 : top_pct(c - 4'h1);
    return p;
  endfunction

  logic tick;
  logic act_rise;
  logic act_fall;
  logic [7:0] sel_duty;
  logic [6:0] sel_per;
  logic [2:0] sel_cnt;
  logic at_end;
  logic [6:0] ramp_duty;

  assign tick = (q_r.tick_cnt == 23'(TICK_CYCLES - 1));
  assign act_rise = act_level && !q_r.act_d;
  assign act_fall = !act_level && q_r.act_d;

  // Settings chosen for the behaviour being started.
  always_comb begin
    sel_per = q_r.breathe_period_field[6:0];
    sel_cnt = 3'h0;
    case (led_behaviour_select)
      LPB_BEH_DIRECT: sel_duty = q_r.dr_duty;
      LPB_BEH_PULSE1: begin
        sel_duty = q_r.p1_duty;
        sel_per = q_r.pulse_two_period_field[6:0];
        sel_cnt = q_r.cfg[`LPB_P1CNT_HI:`LPB_P1CNT_LO];
      end
      LPB_BEH_PULSE2: begin
        sel_duty = q_r.p2_duty;
        sel_per = q_r.pulse_two_period_field[6:0];
        sel_cnt = q_r.cfg[`LPB_P2CNT_HI:`LPB_P2CNT_LO];
      end
      default: sel_duty = q_r.br_duty;
    endcase
  end

  // Duty walks linearly between the latched limits across each half period.
  always_comb begin
    logic [13:0] span;
    span = 14'(q_r.hi - q_r.lo) * 14'(q_r.step);
    ramp_duty = (q_r.half == 7'h0) ? q_r.lo : 7'(q_r.lo + 7'(span / 14'(q_r.half)));
  end
  // A ramp ends on the tick after its last step, so one ramp spans exactly half ticks.
  assign at_end = tick && (q_r.step == 7'(q_r.half - 7'h1));

  always_comb begin
    logic [6:0] p;
    logic [6:0] fl;
    logic [6:0] tp;
    // Period halves in ticks; short periods clamp to the reachable floor.
    p = (sel_per < `LPB_MIN_PER_STEPS) ? `LPB_MIN_PER_STEPS : sel_per;
    // A floor programmed above the top is held at the top so that ramps stay monotonic.
    fl = floor_pct(sel_duty[3:0]);
    tp = top_pct(sel_duty[7:4]);
    q_nxt = q_r;
    q_nxt.act_d = act_level;
    q_nxt.tick_cnt = tick ? 23'h0 : 23'(q_r.tick_cnt + 23'h1);
    q_nxt.alert_n = 1'b1;
    // Register writes; the period bit 7 and config bit 7 read as zero.
    if (reg_wr) begin
      case (reg_addr)
        `LPB_ADDR_PULSE_TWO_PERIOD_FIELD: q_nxt.pulse_two_period_field = reg_wdata & `LPB_PER_MASK;
        `LPB_ADDR_BREATHE_PERIOD_FIELD: q_nxt.breathe_period_field = reg_wdata & `LPB_PER_MASK;
        `LPB_ADDR_CFG: q_nxt.cfg = reg_wdata & `LPB_CFG_MASK;
        `LPB_ADDR_P1_DUTY: q_nxt.p1_duty = reg_wdata;
        `LPB_ADDR_P2_DUTY: q_nxt.p2_duty = reg_wdata;
        `LPB_ADDR_BR_DUTY: q_nxt.br_duty = reg_wdata;
        `LPB_ADDR_DR_DUTY: q_nxt.dr_duty = reg_wdata;
        default: ;
      endcase
    end
    case (reg_addr)
      `LPB_ADDR_PULSE_TWO_PERIOD_FIELD: q_nxt.rdata = q_r.pulse_two_period_field;
      `LPB_ADDR_BREATHE_PERIOD_FIELD: q_nxt.rdata = q_r.breathe_period_field;
      `LPB_ADDR_CFG: q_nxt.rdata = q_r.cfg;
      `LPB_ADDR_P1_DUTY: q_nxt.rdata = q_r.p1_duty;
      `LPB_ADDR_P2_DUTY: q_nxt.rdata = q_r.p2_duty;
      `LPB_ADDR_BR_DUTY: q_nxt.rdata = q_r.br_duty;
      `LPB_ADDR_DR_DUTY: q_nxt.rdata = q_r.dr_duty;
      default: q_nxt.rdata = 8'h00;
    endcase
    // Actuation latches the ramp settings; later writes wait for re-actuation, except dr_duty, which Direct follows live.
    if (act_rise || (act_fall && led_behaviour_select == LPB_BEH_PULSE1)) begin
      q_nxt.beh = led_behaviour_select;
      q_nxt.lo = (fl > tp) ? tp : fl;
      q_nxt.hi = tp;
      q_nxt.half = 7'(p >> 1);
      q_nxt.left = {1'b0, sel_cnt} + 4'h1;
      q_nxt.host = act_by_host;
      q_nxt.stopping = (led_behaviour_select == LPB_BEH_PULSE1);
      q_nxt.step = 7'h0;
      q_nxt.st = LPB_ST_RISE;
    end else if (act_fall && q_r.st != LPB_ST_IDLE) begin
      if (q_r.beh == LPB_BEH_PULSE2) begin
        q_nxt.stopping = 1'b1;
      end else if (q_r.beh != LPB_BEH_PULSE1) begin
        q_nxt.st = LPB_ST_IDLE;
        q_nxt.alert_n = !(q_r.host && q_r.cfg[`LPB_ALERT_BIT]);
      end
    end else begin
      case (q_r.st)
        LPB_ST_RISE: begin
          if (q_r.beh == LPB_BEH_DIRECT) begin
            q_nxt.st = LPB_ST_RISE;
          end else if (at_end) begin
            q_nxt.st = LPB_ST_FALL;
            q_nxt.step = 7'h0;
          end else if (tick) begin
            q_nxt.step = 7'(q_r.step + 7'h1);
          end
        end
        LPB_ST_FALL: begin
          if (at_end) begin
            q_nxt.step = 7'h0;
            q_nxt.st = LPB_ST_RISE;
            if (q_r.stopping) begin
              q_nxt.left = 4'(q_r.left - 4'h1);
              if (q_r.left == 4'h1) begin
                q_nxt.st = LPB_ST_HOLD;
                q_nxt.alert_n = !(q_r.host && q_r.cfg[`LPB_ALERT_BIT]);
              end
            end
          end else if (tick) begin
            q_nxt.step = 7'(q_r.step + 7'h1);
          end
        end
        LPB_ST_HOLD: q_nxt.st = LPB_ST_HOLD;
        default: q_nxt.st = LPB_ST_IDLE;
      endcase
    end
    // Direct follows its duty register live, no re-actuation needed.
    case (q_r.st)
      LPB_ST_RISE: begin
        if (q_r.beh == LPB_BEH_DIRECT) begin
          q_nxt.duty = top_pct(q_r.dr_duty[7:4]);
        end else begin
          q_nxt.duty = ramp_duty;
        end
      end
      LPB_ST_FALL: q_nxt.duty = 7'(q_r.hi - (ramp_duty - q_r.lo));
      LPB_ST_HOLD: q_nxt.duty = q_r.lo;
      default: begin
        if (led_behaviour_select == LPB_BEH_DIRECT) begin
          q_nxt.duty = floor_pct(q_r.dr_duty[3:0]);
        end else begin
          q_nxt.duty = q_r.lo;
        end
      end
    endcase
    // PWM counter runs 0..99; polarity 1 drives high for the on share.
    q_nxt.pwm_cnt = (q_r.pwm_cnt == 7'(`LPB_PWM_MAX - 7'h1)) ? 7'h0 : 7'(q_r.pwm_cnt + 7'h1);
    q_nxt.pwm = (q_r.pwm_cnt < q_r.duty) ? led_polarity : !led_polarity;
  end

  // All state lives in one register; reset is synchronous.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q_r <= '0;
      q_r.pulse_two_period_field <= `LPB_RST_PULSE_TWO_PERIOD_FIELD;
      q_r.breathe_period_field <= `LPB_RST_BREATHE_PERIOD_FIELD;
      q_r.cfg <= `LPB_RST_CFG;
      q_r.p1_duty <= `LPB_RST_DUTY;
      q_r.p2_duty <= `LPB_RST_DUTY;
      q_r.br_duty <= `LPB_RST_DUTY;
      q_r.dr_duty <= `LPB_RST_DUTY;
      q_r.alert_n <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata = q_r.rdata;
  assign led_pwm = q_r.pwm;
  assign alert_n = q_r.alert_n;

  // The tick counter restarts once per tick period.
  tick_period_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick |=> q_r.tick_cnt == 23'h0)
    else $error("Tick counter did not wrap.");
  // Completion alerts only follow host-started effects with the alert bit set.
  alert_host_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !alert_n |-> $past(q_r.host) && $past(q_r.cfg[`LPB_ALERT_BIT]))
    else $error("Alert without host start and enable.");
  // The alert is a single-cycle pulse.
  alert_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !alert_n |=> alert_n)
    else $error("Alert held longer than a cycle.");
  // A ramping effect never runs on a half period below the clamp.
  half_min_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.st == LPB_ST_RISE && q_r.beh != LPB_BEH_DIRECT |-> q_r.half >= 7'h2)
    else $error("Half period below the clamp.");
  // The falling ramp stays between the limits it was started with.
  duty_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.st == LPB_ST_FALL |=> q_r.duty <= $past(q_r.hi) && q_r.duty >= $past(q_r.lo))
    else $error("Ramp duty outside limits.");
  // A settled LED sits at its floor duty.
  hold_floor_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.st == LPB_ST_HOLD ##1 q_r.st == LPB_ST_HOLD |-> q_r.duty == q_r.lo)
    else $error("Settled LED not at floor duty.");
  // Starting a Pulse 2 effect loads the breath count as code plus one.
  count_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    act_rise && led_behaviour_select == LPB_BEH_PULSE2 |=>
    q_r.left == {1'b0, $past(q_r.cfg[`LPB_P2CNT_HI:`LPB_P2CNT_LO])} + 4'h1)
    else $error("Breath count not code plus one.");
  // Starting a Pulse 1 effect loads its own breath count the same way.
  p1_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    act_rise && led_behaviour_select == LPB_BEH_PULSE1 |=>
    q_r.left == {1'b0, $past(q_r.cfg[`LPB_P1CNT_HI:`LPB_P1CNT_LO])} + 4'h1)
    else $error("Pulse 1 count not code plus one.");
  // Direct duty follows its duty register on the next cycle.
  direct_live_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.st == LPB_ST_RISE && q_r.beh == LPB_BEH_DIRECT && !act_fall |=>
    q_r.duty == top_pct($past(q_r.dr_duty[7:4])))
    else $error("Direct duty not applied at once.");
  // Every rising actuation edge restarts the ramp from its first step.
  ramp_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    act_rise |=> q_r.st == LPB_ST_RISE && q_r.step == 7'h0)
    else $error("Actuation did not start a ramp.");
  // The host flag is taken from the actuation source at the start edge.
  host_latch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    act_rise |=> q_r.host == $past(act_by_host))
    else $error("Actuation source not latched.");
  // The step counter never passes the last step of a half period.
  ramp_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.st != LPB_ST_IDLE |-> q_r.step < q_r.half)
    else $error("Ramp step beyond half period.");
  // A latched floor never lies above the latched top.
  floor_top_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.st != LPB_ST_IDLE |-> q_r.lo <= q_r.hi)
    else $error("Floor duty above top duty.");
  // The end of a rise hands over to the fall on the same tick.
  ramp_turn_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.st == LPB_ST_RISE && q_r.beh != LPB_BEH_DIRECT && at_end && !act_rise && !act_fall
    |=> q_r.st == LPB_ST_FALL && q_r.step == 7'h0)
    else $error("Rise did not turn into a fall.");
  // The first step of a fall drives the top duty.
  peak_duty_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.st == LPB_ST_FALL && q_r.step == 7'h0 |=> q_r.duty == $past(q_r.hi))
    else $error("Fall did not start at top duty.");
  // Stopping a breathe effect returns it to idle.
  breathe_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    act_fall && q_r.st != LPB_ST_IDLE && q_r.beh == LPB_BEH_BREATHE &&
    led_behaviour_select != LPB_BEH_PULSE1 |=> q_r.st == LPB_ST_IDLE)
    else $error("Breathe did not stop on release.");
  // Stopping a Pulse 2 effect starts the breath countdown.
  p2_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    act_fall && q_r.st != LPB_ST_IDLE && q_r.beh == LPB_BEH_PULSE2 &&
    led_behaviour_select != LPB_BEH_PULSE1 |=> q_r.stopping)
    else $error("Pulse 2 did not start counting.");
  // The PWM counter wraps after one hundred clocks, one clock per percent.
  pwm_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.pwm_cnt == 7'(`LPB_PWM_MAX - 7'h1) |=> q_r.pwm_cnt == 7'h0)
    else $error("PWM counter did not wrap.");
endmodule

// ---- verif/lpbpwm_led_model.sv ----
// LED seen through its PWM drive: brightness as on-time in a sliding window.
// Assumes led_pwm is registered on ref_clk and the PWM period is 100 clocks.
`timescale 1ns/1ps
module lpbpwm_led_model (
  input wire logic ref_clk,
  input wire logic led_pwm,
  input wire logic led_polarity,
  output logic [6:0] duty_pct
);
  logic [99:0] hist_r;
  // The window spans one PWM period, so its phase against the PWM does not matter.
  always_ff @(posedge ref_clk) begin
    hist_r <= {hist_r[98:0], led_pwm == led_polarity};
  end
  // Brightness in percent; only valid once a full period has been seen.
  assign duty_pct = 7'($countones(hist_r));
endmodule

// ---- verif/tb.sv ----
// Self-checking bench of the LED effect engine with a brightness model on its PWM pin.
// Assumes a short tick parameter so that effects finish within a few hundred clocks.
`timescale 1ns/1ps
module tb;
  import lpbpwm_pkg::*;
  localparam int TK = 10;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic act_level = 1'b0;
  logic act_by_host = 1'b1;
  logic led_polarity = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  lpb_beh_t led_behaviour_select = LPB_BEH_DIRECT;
  logic [7:0] reg_rdata;
  logic [7:0] rv;
  logic [7:0] d;
  logic led_pwm;
  logic alert_n;
  logic [6:0] duty_pct;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 36318;
  logic [7:0] adr [8] = '{8'h85, 8'h86, 8'h88, 8'h90, 8'h91, 8'h92, 8'h93, 8'h87};
  logic [7:0] rst [8] = '{8'h14, 8'h5d, 8'h04, 8'hf0, 8'hf0, 8'hf0, 8'hf0, 8'h00};
  logic [7:0] msk [8] = '{8'h7f, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
  logic [6:0] dtab [17] = '{7'h00, 7'h07, 7'h09, 7'h0b, 7'h0e, 7'h11, 7'h14, 7'h17, 7'h1a,
    7'h1e, 7'h23, 7'h28, 7'h2e, 7'h35, 7'h3f, 7'h4d, 7'h64};

  // Free-running 25 MHz clock.
  always #20 ref_clk = ~ref_clk;

  lpbpwm_top #(.TICK_CYCLES(TK)) lpbpwm_top_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .led_behaviour_select(led_behaviour_select), .led_polarity(led_polarity),
    .act_level(act_level), .act_by_host(act_by_host), .led_pwm(led_pwm),
    .alert_n(alert_n));
  lpbpwm_led_model lpbpwm_led_model_i (.ref_clk(ref_clk), .led_pwm(led_pwm),
    .led_polarity(led_polarity), .duty_pct(duty_pct));

  // Duty decode: the floor table is the top table shifted by one code.
  function automatic logic [7:0] dmax(input int c);
    return {1'b0, dtab[c + 1]};
  endfunction
  function automatic logic [7:0] dmin(input int c);
    return {1'b0, dtab[c]};
  endfunction

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The strobe drops a full cycle before the next write, so writes never merge.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask

  task automatic act(input logic lvl, input int w);
    @(negedge ref_clk);
    act_level = lvl;
    repeat (w) @(negedge ref_clk);
  endtask

  // A completion pulse lasts one cycle, so alert_n is looked at every cycle.
  task automatic wait_alert(input int lo, input int hi);
    int c;
    c = 0;
    while (alert_n !== 1'b0 && c < hi) begin
      @(negedge ref_clk);
      c++;
    end
    if (c >= hi) begin
      error_cnt++;
      $display("wrong value alert delay expected below %0d seen %0d", hi, c);
      end_sim();
    end
    chk("alert not early", 8'h01, 8'(c >= lo));
  endtask

  // Run-length guard against a hang anywhere in the sequence.
  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    end_sim();
  end

  initial begin
    int cnt;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(adr[i], rv);
      chk("reset value", rst[i], rv);
      d = 8'($random(seed));
      wr(adr[i], d);
      rd(adr[i], rv);
      chk("readback", d & msk[i], rv);
    end
    led_polarity = 1'($random(seed));
    wr(8'h88, 8'h40);
    act(1'b1, 2);
    for (int i = 0; i < 16; i++) begin
      wr(8'h93, {4'(i), 4'(i)});
      repeat (130) @(negedge ref_clk);
      chk("direct top", dmax(i), {1'b0, duty_pct});
      act(1'b0, 130);
      chk("direct floor", dmin(i), {1'b0, duty_pct});
      act(1'b1, 2);
    end
    act(1'b0, 20);
    led_behaviour_select = LPB_BEH_BREATHE;
    wr(8'h86, 8'h02);
    wr(8'h92, 8'h01);
    act(1'b1, 130);
    chk("breathe level", dmin(1), {1'b0, duty_pct});
    wr(8'h92, 8'hef);
    repeat (130) @(negedge ref_clk);
    chk("breathe held", dmin(1), {1'b0, duty_pct});
    act(1'b0, 0);
    wait_alert(0, 6 * TK + 10);
    act(1'b1, 130);
    chk("breathe new", dmax(14), {1'b0, duty_pct});
    act(1'b0, 100);
    act_by_host = 1'b0;
    act(1'b1, 50);
    act(1'b0, 0);
    cnt = 0;
    repeat (100) begin
      @(negedge ref_clk);
      cnt += (alert_n !== 1'b1);
    end
    chk("touch alert count", 8'h00, 8'(cnt));
    act_by_host = 1'b1;
    led_behaviour_select = LPB_BEH_PULSE2;
    wr(8'h85, 8'h06);
    for (int i = 0; i < 8; i++) begin
      wr(8'h88, 8'h40 | 8'(i << 3));
      act(1'b1, 100);
      act(1'b0, 0);
      wait_alert(i * 60, (i + 2) * 60 + 30);
    end
    led_behaviour_select = LPB_BEH_PULSE1;
    for (int i = 0; i < 8; i++) begin
      wr(8'h88, 8'h40 | 8'(i));
      act(1'b1, 0);
      wait_alert(i * 60 + 40, i * 60 + 90);
      act(1'b0, 0);
      wait_alert(i * 60 + 40, i * 60 + 90);
    end
    // A period below the clamp must still run one breath of the clamped length.
    wr(8'h85, 8'h02);
    wr(8'h88, 8'h40);
    act(1'b1, 0);
    wait_alert(28, 50);
    end_sim();
  end
endmodule
